// file: ppjd_top.sv
// paper path jam detector: times sensors against clutch and motor start
// Behaviour
// - jam 1 if registration sensor not on 2.52 s after cassette clutch on
// - jam 2 if registration sensor not off within pass time plus 3 s
// - pass times per paper size in ms, from 1273 up to 3059
// - jam 3 if exit sensor not on 1.94 s after registration on
// - jam 4 if exit sensor not off 2.99 s after registration off
// - jam 5 if registration not on 1.72 s after main motor start (bypass)
`timescale 1ns/10ps
`default_nettype none
`include "ppjd_regs.svh"
module ppjd_top
#(
  // clock cycles per millisecond tick
  parameter int TICK_CYC = `PPJD_TICK_CYC
)
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // sensors and drives from the paper path, with bypass mode and paper size
  input wire logic i_reg_sensor,
  input wire logic i_exit_sensor,
  input wire logic i_clutch_on,
  input wire logic i_motor_on,
  input wire logic i_bypass,
  input wire ppjd_pkg::ppjd_size_t i_size,
  // jam clear
  input wire logic i_jam_clear,
  // jam report
  output logic o_jam,
  output logic [2:0] o_jam_code
);
  import ppjd_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] reg_s_q;
  logic [2:0] exit_s_q;
  logic [2:0] clu_s_q;
  logic [2:0] mot_s_q;
  logic reg_q;
  logic exit_q;
  logic clu_q;
  logic mot_q;
  logic clu_prev_q;
  logic mot_prev_q;
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      reg_s_q <= 3'h0;
      exit_s_q <= 3'h0;
      clu_s_q <= 3'h0;
      mot_s_q <= 3'h0;
    end
    else
    begin
      reg_s_q <= {reg_s_q[1:0], i_reg_sensor};
      exit_s_q <= {exit_s_q[1:0], i_exit_sensor};
      clu_s_q <= {clu_s_q[1:0], i_clutch_on};
      mot_s_q <= {mot_s_q[1:0], i_motor_on};
    end
  end
  // a level counts once the second and third stages agree
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      reg_q <= 1'b0;
      exit_q <= 1'b0;
      clu_q <= 1'b0;
      mot_q <= 1'b0;
      clu_prev_q <= 1'b0;
      mot_prev_q <= 1'b0;
    end
    else
    begin
      if (reg_s_q[1] == reg_s_q[2]) reg_q <= reg_s_q[2];
      if (exit_s_q[1] == exit_s_q[2]) exit_q <= exit_s_q[2];
      if (clu_s_q[1] == clu_s_q[2]) clu_q <= clu_s_q[2];
      if (mot_s_q[1] == mot_s_q[2]) mot_q <= mot_s_q[2];
      clu_prev_q <= clu_q;
      mot_prev_q <= mot_q;
    end
  end
  wire clu_rise = clu_q & ~clu_prev_q;
  wire mot_rise = mot_q & ~mot_prev_q & i_bypass;

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  logic [16:0] div_q;
  wire tick = (div_q == 17'(TICK_CYC - 1));
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst) div_q <= 17'h0_0000;
    else div_q <= tick ? 17'h0_0000 : div_q + 17'h0_0001;
  end
  // cycles since the last tick, kept apart from the divider for the period check
  logic [16:0] gap_q;
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst) gap_q <= 17'h0_0000;
    else gap_q <= tick ? 17'h0_0000 : gap_q + 17'h0_0001;
  end

  // ----------------------------------------
  // pass time lookup
  // ----------------------------------------
  logic [11:0] pass_ms;
  always_comb
  begin
    case (i_size)
      PPJD_SZ_A4SEF: pass_ms = 12'(`PPJD_PASS_A4SEF);
      PPJD_SZ_A5SEF: pass_ms = 12'(`PPJD_PASS_A5SEF);
      PPJD_SZ_A5LEF: pass_ms = 12'(`PPJD_PASS_A5LEF);
      PPJD_SZ_A6SEF: pass_ms = 12'(`PPJD_PASS_A6SEF);
      PPJD_SZ_B5SEF: pass_ms = 12'(`PPJD_PASS_B5SEF);
      PPJD_SZ_B6SEF: pass_ms = 12'(`PPJD_PASS_B6SEF);
      PPJD_SZ_LTR: pass_ms = 12'(`PPJD_PASS_LTR);
      PPJD_SZ_LGL: pass_ms = 12'(`PPJD_PASS_LGL);
      PPJD_SZ_ENV: pass_ms = 12'(`PPJD_PASS_ENV);
      default: pass_ms = 12'(`PPJD_PASS_LGL);
    endcase
  end
  wire [12:0] jam2_lim = 13'(pass_ms) + 13'(`PPJD_JAM2_EXTRA_MS);

  // ----------------------------------------
  // supervision state machine
  // ----------------------------------------
  ppjd_state_t st_q;
  ppjd_state_t st_d;
  logic [12:0] t_q;
  logic [12:0] te_q;
  logic wait_byp_q;
  logic exit_seen_q;
  logic [2:0] code_q;
  logic [2:0] code_d;
  wire [12:0] reg_lim = wait_byp_q ? 13'(`PPJD_JAM5_MS) : 13'(`PPJD_JAM1_MS);
  wire start = clu_rise | mot_rise;
  wire t_over = tick & (t_q >= reg_lim - 13'h0001);
  wire j2_over = tick & (t_q >= jam2_lim - 13'h0001);
  wire j3_over = tick & ~exit_seen_q & (te_q >= 13'(`PPJD_JAM3_MS) - 13'h0001);
  wire j4_over = tick & (te_q >= 13'(`PPJD_JAM4_MS) - 13'h0001);

  always_comb
  begin
    st_d = st_q;
    code_d = code_q;
    case (st_q)
      PPJD_IDLE:
        if (start) st_d = PPJD_WAIT_REG;
      PPJD_WAIT_REG:
        if (reg_q) st_d = PPJD_REG_ON;
        else if (t_over)
        begin
          st_d = PPJD_JAMMED;
          code_d = wait_byp_q ? `PPJD_JAM_5 : `PPJD_JAM_1;
        end
      PPJD_REG_ON:
        if (j3_over)
        begin
          st_d = PPJD_JAMMED;
          code_d = `PPJD_JAM_3;
        end
        else if (j2_over)
        begin
          st_d = PPJD_JAMMED;
          code_d = `PPJD_JAM_2;
        end
        else if (!reg_q) st_d = PPJD_REG_OFF;
      PPJD_REG_OFF:
        if (!exit_q && exit_seen_q) st_d = PPJD_IDLE;
        else if (j4_over)
        begin
          st_d = PPJD_JAMMED;
          code_d = `PPJD_JAM_4;
        end
      PPJD_JAMMED:
        if (i_jam_clear)
        begin
          st_d = PPJD_IDLE;
          code_d = `PPJD_JAM_NONE;
        end
      default: st_d = PPJD_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= PPJD_IDLE;
      code_q <= `PPJD_JAM_NONE;
    end
    else
    begin
      st_q <= st_d;
      code_q <= code_d;
    end
  end

  // interval timers restart on each state entry
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      t_q <= 13'h0000;
      te_q <= 13'h0000;
      wait_byp_q <= 1'b0;
      exit_seen_q <= 1'b0;
    end
    else
    begin
      if (st_q == PPJD_IDLE && start) wait_byp_q <= mot_rise & ~clu_rise;
      if (st_q != st_d)
      begin
        t_q <= 13'h0000;
        te_q <= 13'h0000;
      end
      else if (tick)
      begin
        t_q <= t_q + 13'h0001;
        te_q <= te_q + 13'h0001;
      end
      if (st_q == PPJD_WAIT_REG) exit_seen_q <= 1'b0;
      else if (exit_q) exit_seen_q <= 1'b1;
    end
  end

  assign o_jam_code = code_q;
  assign o_jam = (code_q != `PPJD_JAM_NONE);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_TICK_PERIOD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    tick |-> (gap_q == 17'(TICK_CYC - 1)))
    else $error("tick period wrong");
  AST_JAM_HOLD: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (o_jam && !i_jam_clear) |=> $stable(o_jam_code))
    else $error("jam code changed without clear");
  AST_CLEAR: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_JAMMED && i_jam_clear) |=> !o_jam)
    else $error("clear did not drop jam");
  AST_JAM1: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_WAIT_REG && !wait_byp_q && !reg_q && tick
     && t_q == 13'(`PPJD_JAM1_MS - 1)) |=> (o_jam_code == `PPJD_JAM_1))
    else $error("jam 1 missed");
  AST_JAM5: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_WAIT_REG && wait_byp_q && !reg_q && tick
     && t_q == 13'(`PPJD_JAM5_MS - 1)) |=> (o_jam_code == `PPJD_JAM_5))
    else $error("jam 5 missed");
  AST_JAM2_LIM: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_REG_ON && st_d == PPJD_JAMMED && code_d == `PPJD_JAM_2)
    |-> (t_q + 13'h0001 >= jam2_lim))
    else $error("jam 2 too early");
  AST_PASS_LGL: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_size == PPJD_SZ_LGL) |-> (jam2_lim == 13'(6059)))
    else $error("legal pass limit wrong");
  AST_JAM3: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_REG_ON && !exit_seen_q && tick
     && te_q == 13'(`PPJD_JAM3_MS - 1)) |=> (o_jam_code == `PPJD_JAM_3))
    else $error("jam 3 missed");
  AST_JAM4: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (st_q == PPJD_REG_OFF && !(exit_seen_q && !exit_q) && tick
     && te_q == 13'(`PPJD_JAM4_MS - 1)) |=> (o_jam_code == `PPJD_JAM_4))
    else $error("jam 4 missed");
  COV_JAM1: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_jam_code == `PPJD_JAM_1);
  COV_JAM3: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_jam_code == `PPJD_JAM_3);
  COV_JAM4: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_jam_code == `PPJD_JAM_4);
  COV_GOOD: cover property (@(posedge i_mclk) disable iff (!i_nrst)
    st_q == PPJD_REG_OFF ##1 st_q == PPJD_IDLE);
endmodule
`default_nettype wire

// file: ppjd_regs.svh
// timing constants and paper size pass times for the paper path jam detector
`ifndef PPJD_REGS_SVH
`define PPJD_REGS_SVH
`define PPJD_CLK_HZ 125000000
`define PPJD_TICK_MS 1
`define PPJD_TICK_CYC ((`PPJD_CLK_HZ / 1000) * `PPJD_TICK_MS)
`define PPJD_JAM1_MS 2520
`define PPJD_JAM2_EXTRA_MS 3000
`define PPJD_JAM3_MS 1940
`define PPJD_JAM4_MS 2990
`define PPJD_JAM5_MS 1720
`define PPJD_PASS_A4SEF 2555
`define PPJD_PASS_A5SEF 1807
`define PPJD_PASS_A5LEF 1273
`define PPJD_PASS_A6SEF 1273
`define PPJD_PASS_B5SEF 2211
`define PPJD_PASS_B6SEF 1566
`define PPJD_PASS_LTR 2400
`define PPJD_PASS_LGL 3059
`define PPJD_PASS_ENV 1643
`define PPJD_JAM_NONE 3'h0
`define PPJD_JAM_1 3'h1
`define PPJD_JAM_2 3'h2
`define PPJD_JAM_3 3'h3
`define PPJD_JAM_4 3'h4
`define PPJD_JAM_5 3'h5
`endif

// file: ppjd_pkg.sv
// types for the paper path jam detector
package ppjd_pkg;
  typedef enum logic [3:0] {
    PPJD_SZ_A4SEF,
    PPJD_SZ_A5SEF,
    PPJD_SZ_A5LEF,
    PPJD_SZ_A6SEF,
    PPJD_SZ_B5SEF,
    PPJD_SZ_B6SEF,
    PPJD_SZ_LTR,
    PPJD_SZ_LGL,
    PPJD_SZ_ENV
  } ppjd_size_t;
  typedef enum logic [2:0] {
    PPJD_IDLE,
    PPJD_WAIT_REG,
    PPJD_REG_ON,
    PPJD_REG_OFF,
    PPJD_JAMMED
  } ppjd_state_t;
endpackage

// file: ppjd_path_model.sv
// paper path stand-in: runs one sheet past the sensors on command
`timescale 1ns/10ps
`default_nettype none
module ppjd_path_model
(
  // clock
  input wire logic i_mclk,
  // command from the bench
  input wire logic i_go,
  input wire logic i_bypass,
  input wire logic [7:0] i_stall_step,
  // drives and sensors seen by the detector, and busy back to the bench
  output logic o_clutch_on,
  output logic o_motor_on,
  output logic o_reg_sensor,
  output logic o_exit_sensor,
  output logic o_busy
);
  int step;
  logic go_q = 1'b0;
  initial
  begin
    step = 0;
    o_clutch_on = 1'b0;
    o_motor_on = 1'b0;
    o_reg_sensor = 1'b0;
    o_exit_sensor = 1'b0;
    o_busy = 1'b0;
  end
  // go is taken on the rising edge, away from the bench's falling-edge writes
  always @(posedge i_mclk)
    go_q = i_go;
  // sheet timeline in clock cycles, all far inside every supervision limit;
  // a nonzero stop step freezes the sheet there until the bench lets it go
  always @(negedge i_mclk)
  begin
    if (step == 0)
      step = go_q ? 1 : 0;
    else if (step != int'(i_stall_step))
      step = (step == 200) ? 0 : step + 1;
    o_clutch_on = !i_bypass && step >= 1 && step <= 40;
    o_motor_on = i_bypass && step >= 1 && step <= 190;
    o_reg_sensor = step >= 20 && step < 80;
    o_exit_sensor = step >= 50 && step < 130;
    o_busy = step != 0;
  end
endmodule
`default_nettype wire

// file: ppjd_top_tb.sv
// self-checking bench for the paper path jam detector
`timescale 1ns/10ps
`default_nettype none
`include "ppjd_regs.svh"
module ppjd_top_tb;
  import ppjd_pkg::*;
  // short tick keeps every jam limit inside a short run
  localparam int TICK = 4;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic go = 1'b0;
  logic bypass = 1'b0;
  logic i_jam_clear = 1'b0;
  logic [7:0] stall = 8'h00;
  ppjd_size_t i_size = PPJD_SZ_A4SEF;
  logic clutch_on, motor_on, reg_sensor, exit_sensor, busy, o_jam;
  logic [2:0] o_jam_code;
  int mismatches = 0;
  int samples_checked = 0;
  always #4 i_mclk = ~i_mclk;
  ppjd_path_model path (.i_mclk(i_mclk), .i_go(go), .i_bypass(bypass), .i_stall_step(stall),
    .o_clutch_on(clutch_on), .o_motor_on(motor_on), .o_reg_sensor(reg_sensor),
    .o_exit_sensor(exit_sensor), .o_busy(busy));
  ppjd_top #(.TICK_CYC(TICK)) DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reg_sensor(reg_sensor),
    .i_exit_sensor(exit_sensor), .i_clutch_on(clutch_on), .i_motor_on(motor_on),
    .i_bypass(bypass), .i_size(i_size), .i_jam_clear(i_jam_clear),
    .o_jam(o_jam), .o_jam_code(o_jam_code));
  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // start a sheet; the model stops it at step stop until released (0: no stop)
  task automatic start_sheet(input logic byp, input ppjd_size_t sz, input logic [7:0] stop);
    @(negedge i_mclk);
    bypass = byp;
    i_size = sz;
    stall = stop;
    go = 1'b1;
    @(negedge i_mclk);
    go = 1'b0;
    @(posedge i_mclk);
  endtask
  // a stopped sheet: the jam must show inside its window, hold, and clear
  task automatic run_jam(input logic byp, input ppjd_size_t sz, input logic [7:0] stop,
    input int ref_step, input int lim_ms, input logic [2:0] code, input string name);
    int n;
    int lo;
    int hi;
    logic ok;
    logic [3:0] exp4;
    string what;
    lo = ref_step + (lim_ms - 1) * TICK;
    hi = ref_step + lim_ms * TICK + 12;
    exp4 = {1'b0, code};
    start_sheet(byp, sz, stop);
    for (n = 1; n < hi + 8 && !o_jam; n++)
      @(negedge i_mclk);
    if (!o_jam)
    begin
      mismatches++;
      end_of_test();
    end
    ok = (n >= lo) && (n <= hi);
    what = {name, " time"};
    check(what, {3'h0, ok}, 4'h1);
    what = {name, " code"};
    check(what, {1'b0, o_jam_code}, exp4);
    repeat (40) @(negedge i_mclk);
    what = {name, " held"};
    check(what, {1'b0, o_jam_code}, exp4);
    // let the sheet run out; the held jam ignores the sensors meanwhile
    @(posedge i_mclk);
    stall = 8'h00;
    for (n = 0; n < 2000 && busy; n++)
      @(posedge i_mclk);
    if (busy)
    begin
      mismatches++;
      end_of_test();
    end
    @(negedge i_mclk);
    what = {name, " kept"};
    check(what, {1'b0, o_jam_code}, exp4);
    i_jam_clear = 1'b1;
    @(negedge i_mclk);
    i_jam_clear = 1'b0;
    what = {name, " cleared"};
    check(what, {1'b0, o_jam_code}, 4'h0);
    check(what, {3'h0, o_jam}, 4'h0);
  endtask
  // one sheet through the path; a jam must never show on a healthy sheet
  task automatic run_sheet(input logic byp, input ppjd_size_t sz);
    logic seen;
    int n;
    seen = 1'b0;
    start_sheet(byp, sz, 8'h00);
    for (n = 0; n < 2000 && busy; n++)
    begin
      @(negedge i_mclk);
      seen = seen | o_jam | (o_jam_code != 3'h0);
      @(posedge i_mclk);
    end
    if (busy)
    begin
      mismatches++;
      end_of_test();
    end
    repeat (20) @(negedge i_mclk);
    check("sheet jam", {3'h0, seen}, 4'h0);
    check("jam code after sheet", {1'b0, o_jam_code}, 4'h0);
  endtask
  task automatic clear_when_idle();
    @(negedge i_mclk);
    i_jam_clear = 1'b1;
    @(negedge i_mclk);
    i_jam_clear = 1'b0;
    @(negedge i_mclk);
    check("code after idle clear", {1'b0, o_jam_code}, 4'h0);
    check("flag after idle clear", {3'h0, o_jam}, 4'h0);
  endtask
  task automatic reset_mid_sheet();
    @(negedge i_mclk);
    go = 1'b1;
    @(negedge i_mclk);
    go = 1'b0;
    repeat (60) @(negedge i_mclk);
    i_nrst = 1'b0;
    @(negedge i_mclk);
    check("code in reset", {1'b0, o_jam_code}, 4'h0);
    repeat (200) @(negedge i_mclk);
    i_nrst = 1'b1;
    repeat (5) @(negedge i_mclk);
    check("flag after reset", {3'h0, o_jam}, 4'h0);
  endtask
  initial
  begin
    ppjd_size_t sz;
    repeat (12) @(negedge i_mclk);
    check("code after reset", {1'b0, o_jam_code}, 4'h0);
    i_nrst = 1'b1;
    repeat (2) @(negedge i_mclk);
    check("flag after reset", {3'h0, o_jam}, 4'h0);
    sz = sz.first();
    for (int i = 0; i < sz.num(); i++)
    begin
      run_sheet(1'b0, sz);
      run_sheet(1'b1, sz);
      sz = sz.next();
    end
    run_sheet(1'b0, PPJD_SZ_LGL);
    run_sheet(1'b1, PPJD_SZ_A6SEF);
    run_jam(1'b0, PPJD_SZ_A4SEF, 8'h0a, 1, `PPJD_JAM1_MS, `PPJD_JAM_1, "jam 1");
    run_jam(1'b1, PPJD_SZ_A4SEF, 8'h0a, 1, `PPJD_JAM5_MS, `PPJD_JAM_5, "jam 5");
    run_jam(1'b0, PPJD_SZ_A4SEF, 8'h28, 20, `PPJD_JAM3_MS, `PPJD_JAM_3, "jam 3");
    run_jam(1'b0, PPJD_SZ_A6SEF, 8'h3c, 20, `PPJD_PASS_A6SEF + `PPJD_JAM2_EXTRA_MS, `PPJD_JAM_2,
      "jam 2");
    run_jam(1'b0, PPJD_SZ_A4SEF, 8'h64, 80, `PPJD_JAM4_MS, `PPJD_JAM_4, "jam 4");
    clear_when_idle();
    reset_mid_sheet();
    run_sheet(1'b0, PPJD_SZ_ENV);
    end_of_test();
  end
endmodule
`default_nettype wire
